// File: verilog/rpx_top.v
/*
  row pointer and output crossbar control with a classic wishbone slave.
  assumes camera controller pins are asynchronous to clk_i and are
  synchronised here; wishbone master is on clk_i.
  unmapped reads return zero and unmapped writes are dropped; every
  bus request is answered on the next edge.
*/
`timescale 1ns/10ps
`include "rpx_regs.vh"
// What this block does
// - a read pointer and a reset pointer are kept apart, the reset one leading by a set count.
// - every row read is also reset afterwards for double sampling.
// - the signal level is held, then the reset level, and the two are subtracted.
// - the array spans 4536 by 3024 active pixels plus 24 extra columns and rows.
// - subsampling, amplifier power and extras come from the configuration word.
// - each output amplifier has its own operate or standby bit.
// - the crossbar keeps green pixels on one output.
// - the crossbar runs either auto toggling or manual state from configuration.
// - in auto mode the crossbar inverts on every crossbar row clock rising edge that comes without sync.
// - a crossbar sync loads the crossbar state from the initial configuration bit.
// - pixel (0,0) is green on a green-red row, so state 0 means green on output 0.
// - each rising edge of a pointer clock moves that pointer to a new row.
// - a sync level sampled on a pointer clock edge returns the pointer to row 0.
module rpx_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [31:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // controller pins
  input  wire        read_pointer_clock_i,
  input  wire        read_pointer_sync_i,
  input  wire        reset_pointer_clock_i,
  input  wire        reset_pointer_sync_i,
  input  wire        xbar_clock_i,
  input  wire        xbar_sync_i,
  // row drive and column stage
  output reg  [11:0] read_row_o,
  output reg  [11:0] reset_row_o,
  output reg         row_reset_o,
  output reg         signal_sample_hold_o,
  output reg         reset_sample_hold_o,
  output reg         subtract_o,
  // crossbar and amplifiers
  output reg         xbar_state_o,
  output reg  [3:0]  amp_enable_o,
  output reg  [2:0]  x_subsample_o,
  output reg  [2:0]  y_subsample_o
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_SIG   = 2'd1;
  localparam ST_RST   = 2'd2;
  localparam ST_SUB   = 2'd3;
  localparam IDX_CTRL = 3'd0;
  localparam IDX_LEAD = 3'd1;
  localparam IDX_STAT = 3'd2;
  localparam IDX_PTRS = 3'd3;
  localparam IDX_NONE = 3'd4;

  wire        rpc_s, rps_s, spc_s, sps_s, xbc_s, xbs_s;
  reg         rpc_d_reg, spc_d_reg, xbc_d_reg;
  reg  [15:0] cfg_reg;
  reg  [11:0] lead_reg;
  reg  [1:0]  st_reg;
  reg  [1:0]  st_next;
  reg         xbar_reg;
  reg         xbar_next;
  reg         ld_reg;
  wire [11:0] rd_row, rs_row;
  wire        rd_adv, rs_adv, xb_adv;
  wire        wb_req;
  wire [2:0]  wb_idx;
  wire [15:0] cfg_merged;
  wire [15:0] lead_merged;
  wire [11:0] rs_load_val;

  function [11:0] wrap_add;
    input [11:0] a;
    input [11:0] b;
    reg   [12:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= `RPX_ROWS_TOTAL)
        s = s - `RPX_ROWS_TOTAL;
      // a lead above the array still lands inside it
      if (s >= `RPX_ROWS_TOTAL)
        s = s - `RPX_ROWS_TOTAL;
      wrap_add = s[11:0];
    end
  endfunction

  // register index from byte address
  function [2:0] reg_index;
    input [31:0] adr;
    begin
      if (adr == `RPX_A_CTRL)
        reg_index = IDX_CTRL;
      else if (adr == `RPX_A_LEAD)
        reg_index = IDX_LEAD;
      else if (adr == `RPX_A_STAT)
        reg_index = IDX_STAT;
      else if (adr == `RPX_A_PTRS)
        reg_index = IDX_PTRS;
      else
        reg_index = IDX_NONE;
    end
  endfunction

  // byte lane merge of a 16-bit word
  function [15:0] lane_merge;
    input [15:0] old_w;
    input [15:0] new_w;
    input [1:0]  lanes;
    begin
      lane_merge = old_w;
      if (lanes[0])
        lane_merge[7:0] = new_w[7:0];
      if (lanes[1])
        lane_merge[15:8] = new_w[15:8];
    end
  endfunction

  // rising edge of a synchronised level
  function rise;
    input now_v;
    input last_v;
    begin
      rise = now_v & ~last_v;
    end
  endfunction

  rpx_sync2 u_s0 (.clk_i(clk_i), .rst_i(rst_i), .d_i(read_pointer_clock_i),  .q_o(rpc_s));
  rpx_sync2 u_s1 (.clk_i(clk_i), .rst_i(rst_i), .d_i(read_pointer_sync_i),   .q_o(rps_s));
  rpx_sync2 u_s2 (.clk_i(clk_i), .rst_i(rst_i), .d_i(reset_pointer_clock_i), .q_o(spc_s));
  rpx_sync2 u_s3 (.clk_i(clk_i), .rst_i(rst_i), .d_i(reset_pointer_sync_i),  .q_o(sps_s));
  rpx_sync2 u_s4 (.clk_i(clk_i), .rst_i(rst_i), .d_i(xbar_clock_i),          .q_o(xbc_s));
  rpx_sync2 u_s5 (.clk_i(clk_i), .rst_i(rst_i), .d_i(xbar_sync_i),           .q_o(xbs_s));

  always @(posedge clk_i) begin
    if (rst_i) begin
      rpc_d_reg <= 1'b0;
      spc_d_reg <= 1'b0;
      xbc_d_reg <= 1'b0;
    end else begin
      rpc_d_reg <= rpc_s;
      spc_d_reg <= spc_s;
      xbc_d_reg <= xbc_s;
    end
  end

  // rising edges of the pointer and crossbar clocks
  assign rd_adv = rise(rpc_s, rpc_d_reg);
  assign rs_adv = rise(spc_s, spc_d_reg);
  assign xb_adv = rise(xbc_s, xbc_d_reg);

  // two independent pointers; lead load places reset ahead of read
  assign rs_load_val = wrap_add(rd_row, lead_reg);
  rpx_rowptr u_rd (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .adv_i      (rd_adv),
    .sync_i     (rps_s),
    .load_val_i (12'h000),
    .load_i     (1'b0),
    .row_o      (rd_row)
  );

  rpx_rowptr u_rs (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .adv_i      (rs_adv),
    .sync_i     (sps_s),
    .load_val_i (rs_load_val),
    .load_i     (ld_reg),
    .row_o      (rs_row)
  );

  // wishbone single cycle slave, ack one cycle after request
  assign wb_req      = cyc_i & stb_i & ~ack_o;
  assign wb_idx      = reg_index(adr_i);
  assign cfg_merged  = lane_merge(cfg_reg, dat_i[15:0], sel_i[1:0]);
  assign lead_merged = lane_merge({4'h0, lead_reg}, dat_i[15:0], sel_i[1:0]);

  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg  <= `RPX_CFG_RESET;
      lead_reg <= `RPX_LEAD_RESET;
      ack_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
      ld_reg   <= 1'b0;
    end else begin
      ack_o  <= wb_req;
      ld_reg <= 1'b0;
      if (wb_req && we_i) begin
        if (wb_idx == IDX_CTRL) begin
          cfg_reg <= cfg_merged;
        end else if (wb_idx == IDX_LEAD) begin
          lead_reg <= lead_merged[11:0];
          ld_reg   <= dat_i[31] & sel_i[3];
        end
      end
      if (wb_req && !we_i) begin
        if (wb_idx == IDX_CTRL)
          dat_o <= {16'h0000, cfg_reg};
        else if (wb_idx == IDX_LEAD)
          dat_o <= {20'h00000, lead_reg};
        else if (wb_idx == IDX_STAT)
          dat_o <= {28'h0000000, st_reg, 1'b0, xbar_reg};
        else if (wb_idx == IDX_PTRS)
          dat_o <= {4'h0, rs_row, 4'h0, rd_row};
        else
          dat_o <= 32'h0000_0000;
      end
    end
  end

  // crossbar: sync load beats toggle; state 0 puts green on output 0
  always @* begin
    xbar_next = xbar_reg;
    if (xb_adv && xbs_s) begin
      xbar_next = cfg_reg[`RPX_CFG_XB_INIT];
    end else if (!cfg_reg[`RPX_CFG_XB_AUTO]) begin
      xbar_next = cfg_reg[`RPX_CFG_XB_MAN];
    end else if (xb_adv) begin
      xbar_next = ~xbar_reg;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      xbar_reg <= 1'b0;
    end else begin
      xbar_reg <= xbar_next;
    end
  end

  // per row: hold signal, reset row, then hold reset level and subtract together
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (rd_adv)
          st_next = ST_SIG;
      end
      ST_SIG:  st_next = ST_RST;
      ST_RST:  st_next = ST_SUB;
      default: st_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // row drive outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      read_row_o  <= 12'h000;
      reset_row_o <= 12'h000;
    end else begin
      read_row_o  <= rd_row;
      reset_row_o <= rs_row;
    end
  end

  // column stage outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      row_reset_o          <= 1'b0;
      signal_sample_hold_o <= 1'b0;
      reset_sample_hold_o  <= 1'b0;
      subtract_o           <= 1'b0;
    end else begin
      row_reset_o          <= (st_reg == ST_RST);
      signal_sample_hold_o <= (st_reg == ST_SIG) | (st_reg == ST_RST) | (st_reg == ST_SUB);
      reset_sample_hold_o  <= (st_reg == ST_SUB);
      subtract_o           <= (st_reg == ST_SUB);
    end
  end

  // crossbar and amplifier outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      xbar_state_o  <= 1'b0;
      amp_enable_o  <= 4'h0;
      x_subsample_o <= 3'h0;
      y_subsample_o <= 3'h0;
    end else begin
      xbar_state_o  <= xbar_reg;
      amp_enable_o  <= cfg_reg[`RPX_CFG_AMP_LSB +: 4];
      x_subsample_o <= cfg_reg[`RPX_CFG_XSUB_LSB +: 3];
      y_subsample_o <= cfg_reg[`RPX_CFG_YSUB_LSB +: 3];
    end
  end

endmodule

// File: shared/rpx_regs.vh
/*
  constants for the row pointer and crossbar control block: array size,
  configuration word layout, reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef RPX_REGS_VH
`define RPX_REGS_VH
`define RPX_ACT_COLS        13'd4536
`define RPX_ACT_ROWS        13'd3024
`define RPX_EXTRA           13'd24
`define RPX_ROWS_TOTAL      13'd3048
`define RPX_COLS_TOTAL      13'd4560
`define RPX_ROW_W           12
`define RPX_CFG_W           16
`define RPX_CFG_XSUB_LSB    0
`define RPX_CFG_YSUB_LSB    3
`define RPX_CFG_AMP_LSB     6
`define RPX_CFG_XB_AUTO     10
`define RPX_CFG_XB_INIT     11
`define RPX_CFG_XB_MAN      12
`define RPX_CFG_RESET       16'h03C1
`define RPX_LEAD_RESET      12'h000
`define RPX_A_CTRL          32'h0000_0000
`define RPX_A_LEAD          32'h0000_0004
`define RPX_A_STAT          32'h0000_0008
`define RPX_A_PTRS          32'h0000_000C
`endif

// File: verilog/rpx_sync2.v
/*
  two flip-flop synchroniser for one pin level.
  assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module rpx_sync2 (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // pin in, level out
  input  wire d_i,
  output reg  q_o
);
  reg meta_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// File: verilog/rpx_rowptr.v
/*
  one row pointer: advances on a clock enable, returns to row 0 when sync is high with it.
  assumes one-cycle advance pulses from synchronised pin edges.
*/
`timescale 1ns/10ps
`include "rpx_regs.vh"
module rpx_rowptr (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_i,
  // control
  input  wire                    adv_i,
  input  wire                    sync_i,
  input  wire [`RPX_ROW_W-1:0]   load_val_i,
  input  wire                    load_i,
  // state
  output reg  [`RPX_ROW_W-1:0]   row_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      row_o <= {`RPX_ROW_W{1'b0}};
    end else if (load_i) begin
      row_o <= load_val_i;
    end else if (adv_i && sync_i) begin
      row_o <= {`RPX_ROW_W{1'b0}};
    end else if (adv_i) begin
      if ({1'b0, row_o} == `RPX_ROWS_TOTAL - 13'd1)
        row_o <= {`RPX_ROW_W{1'b0}};
      else
        row_o <= row_o + 12'h001;
    end
  end
endmodule

// File: bench/rpx_top_chk.sv
/* assertions on the rpx_top ports.
   assumes the bind below attaches it to every rpx_top. */
`timescale 1ns/10ps
module rpx_top_chk (
  // clock, reset and bus
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [31:0] adr_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // rows, column stage, crossbar
  input wire [11:0] read_row_o,
  input wire [11:0] reset_row_o,
  input wire        row_reset_o,
  input wire        signal_sample_hold_o,
  input wire        reset_sample_hold_o,
  input wire        subtract_o,
  input wire        xbar_state_o,
  input wire [3:0]  amp_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] cfg_reg;
  sequence s_ctrl_wr;
    cyc_i && stb_i && we_i && ack_o && adr_i == 32'h0;
  endsequence
  sequence s_read_tail;
    row_reset_o ##1 (reset_sample_hold_o && subtract_o);
  endsequence
  // copy of the configuration word
  always @(posedge clk_i) begin
    if (rst_i)
      cfg_reg <= 16'h03C1;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i == 32'h0)
      cfg_reg <= dat_i[15:0];
  end
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no answer");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_reset_after: assert property ($rose(signal_sample_hold_o) |=> s_read_tail)
    else $error("read row not reset");
  a_sub_in_hold: assert property (subtract_o |-> signal_sample_hold_o && reset_sample_hold_o)
    else $error("subtract outside hold");
  a_row_range: assert property (read_row_o < 12'hBE8 && reset_row_o < 12'hBE8)
    else $error("row out of range");
  a_row_step: assert property ($changed(read_row_o) |->
    read_row_o == 12'h0 || read_row_o == $past(read_row_o) + 12'h1)
    else $error("bad row step");
  a_row_reads: assert property ($changed(read_row_o) |-> $rose(signal_sample_hold_o))
    else $error("row without sampling");
  a_cfg_apply: assert property (s_ctrl_wr |=> ##[0:2] amp_enable_o == cfg_reg[9:6])
    else $error("amp setting lost");
  a_xbar_manual: assert property (s_ctrl_wr ##1 !cfg_reg[10] |-> ##[0:3]
    xbar_state_o == cfg_reg[12])
    else $error("manual crossbar wrong");
endmodule
bind rpx_top rpx_top_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o,
  .read_row_o, .reset_row_o, .row_reset_o, .signal_sample_hold_o, .reset_sample_hold_o,
  .subtract_o, .xbar_state_o, .amp_enable_o);

// File: bench/rpx_ctrl_model.sv
/* camera controller model: row clocks and syncs, 0 read, 1 reset, 2 crossbar.
   assumes pulse is called right after a clk_i edge. */
`timescale 1ns/10ps
module rpx_ctrl_model (
  // clock
  input  wire        clk_i,
  // pins
  output logic [2:0] clk_o,
  output logic [2:0] sync_o
);
  initial clk_o = 3'h0;
  initial sync_o = 3'h0;
  // sync set up before and held through the edge
  task automatic pulse(input int w, input bit s, input int gap);
    sync_o[w] <= s;
    repeat (gap) @(posedge clk_i);
    clk_o[w] <= 1'b1;
    repeat (4) @(posedge clk_i);
    clk_o[w] <= 1'b0;
    sync_o[w] <= 1'b0;
    repeat (gap + 4) @(posedge clk_i);
  endtask
endmodule

// File: bench/rpx_top_tb.sv
/* self-checking bench for rpx_top.
   assumes checker and controller model are compiled first. */
`timescale 1ns/10ps
module rpx_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic        ack_o, xbar_state_o;
  logic [11:0] read_row_o, reset_row_o;
  logic [3:0]  amp_enable_o;
  logic [2:0]  x_subsample_o, y_subsample_o, pclk, psync;
  int          num_errors = 0, tests_run = 0, cyc_cnt = 0, n, lead, k;
  logic [15:0] c;
  always #5 clk_i = ~clk_i;
  rpx_ctrl_model u_ctrl (.clk_i, .clk_o(pclk), .sync_o(psync));
  rpx_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .read_pointer_clock_i(pclk[0]), .read_pointer_sync_i(psync[0]),
    .reset_pointer_clock_i(pclk[1]), .reset_pointer_sync_i(psync[1]),
    .xbar_clock_i(pclk[2]), .xbar_sync_i(psync[2]), .read_row_o, .reset_row_o,
    .row_reset_o(), .signal_sample_hold_o(), .reset_sample_hold_o(), .subtract_o(),
    .xbar_state_o, .amp_enable_o, .x_subsample_o, .y_subsample_o);
  function automatic int exp_row(int r, int l);
    return (r + l) % 3048;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    {cyc_i, stb_i, we_i} <= {2'h3, w};
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(42481));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(amp_enable_o, 4'hF);
    chk({x_subsample_o, y_subsample_o}, 6'h08);
    wb(0, 32'h0, 32'h0);
    chk(q, 32'h03C1);
    wb(0, 32'h10, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      c = 16'($urandom) & 16'h03FF;
      wb(1, 32'h0, {16'h0, c});
      repeat (3) @(posedge clk_i);
      chk(amp_enable_o, c[9:6]);
      chk({x_subsample_o, y_subsample_o}, {c[2:0], c[5:3]});
    end
    u_ctrl.pulse(0, 1, 3);
    n = $urandom_range(5, 1);
    repeat (n) u_ctrl.pulse(0, 0, $urandom_range(6, 3));
    chk(read_row_o, n);
    u_ctrl.pulse(0, 1, 4);
    chk(read_row_o, 0);
    for (int i = 0; i < 2; i++) begin
      lead = i ? 3047 : $urandom_range(3046);
      wb(1, 32'h4, 32'h8000_0000 | lead);
      repeat (3) @(posedge clk_i);
      chk(reset_row_o, exp_row(0, lead));
    end
    wb(0, 32'hC, 32'h0);
    chk(q, exp_row(0, lead) << 16);
    u_ctrl.pulse(1, 0, 3);
    chk(reset_row_o, exp_row(3047, 1));
    for (int i = 0; i < 2; i++) begin
      wb(1, 32'h0, 32'h07C1 | (i << 11));
      u_ctrl.pulse(2, 1, 3);
      chk(xbar_state_o, i);
      k = $urandom_range(4, 1);
      repeat (k) u_ctrl.pulse(2, 0, 3);
      chk(xbar_state_o, i ^ k[0]);
      wb(0, 32'h8, 32'h0);
      chk(q[0], i ^ k[0]);
      wb(1, 32'h0, 32'h03C1 | (i << 12));
      repeat (4) @(posedge clk_i);
      chk(xbar_state_o, i);
    end
    end_sim;
  end
endmodule
